// ### verilog/atw_pkg.sv
// Package: register map, reset values and bus carrier types of the timeout watchdog
package atw_pkg;
	// Register byte offsets
	localparam logic [11:0] ATW_OFS_RELOAD = 12'h000;
	localparam logic [11:0] ATW_OFS_VALUE = 12'h004;
	localparam logic [11:0] ATW_OFS_CONTROL = 12'h008;
	localparam logic [11:0] ATW_OFS_IRQ_CLEAR = 12'h00C;
	localparam logic [11:0] ATW_OFS_RAW_STATUS = 12'h010;
	localparam logic [11:0] ATW_OFS_MASKED_STATUS = 12'h014;
	localparam logic [11:0] ATW_OFS_WRITE_LOCK = 12'hC00;

	// Control field positions
	localparam int ATW_CTRL_IRQ_COUNT_EN = 0;
	localparam int ATW_CTRL_RESET_OUT_EN = 1;

	// Reset values and lock codes
	localparam logic [31:0] ATW_RELOAD_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] ATW_COUNT_RST = 32'hFFFF_FFFF;
	localparam logic [1:0] ATW_CONTROL_RST = 2'h0;
	localparam logic [31:0] ATW_UNLOCK_KEY = 32'h1ACC_E551;
	localparam logic [31:0] ATW_LOCK_READ_LOCKED = 32'h0000_0001;
	localparam logic [31:0] ATW_LOCK_READ_OPEN = 32'h0000_0000;
	localparam logic [31:0] ATW_COUNT_ONE = 32'h0000_0001;
	localparam logic [31:0] ATW_READ_ZERO = 32'h0000_0000;

	// AHB transfer type bit that marks an active transfer
	localparam int ATW_HTRANS_ACTIVE_BIT = 1;

	// Captured address phase
	typedef struct packed {
		logic [11:0] addr;
		logic write;
	} atw_aphase_t;

	// Bus data-phase states, one-hot
	typedef enum logic [3:0] {
		ATW_S_IDLE = 4'b0001,
		ATW_S_WRITE = 4'b0010,
		ATW_S_READ_WAIT = 4'b0100,
		ATW_S_READ_DONE = 4'b1000
	} atw_bus_state_t;
endpackage : atw_pkg

// ### verilog/atw_timeout_watchdog.sv
// Module: timeout watchdog with AHB-Lite register slave and reload down counter
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns

// Behaviour
// - 32-bit counter decrements only on enabled edges
// - At zero raise interrupt, then reload, continue
// - Uncleared interrupt at zero with enable: reset, stop
// - Enable low freezes; enable high reloads first
// - After enable, load on next enabled edge
// - Key unlocks writes; other values lock them
// - Lock read returns one locked, zero open
// - Resets leave unlocked, disabled, counter all ones
// - Clear write clears interrupt and reloads counter
// - Reload write restarts count, keeps interrupt pending
// - Interrupt set on tick, cleared at once
// - Interval is reload plus one enabled periods
// - Reload zero interrupts on every enabled edge
// - Bus reset async assert, sync release
// - Counter reset async assert, sync release
// - Masked status is raw AND enable, drives irq
// - Reset-output enable gates the reset event; the output then stays until counter reset
module atw_timeout_watchdog
	import atw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic count_clock_enable,
	input wire logic count_domain_reset_n,
	output logic timeout_irq,
	output logic timeout_reset_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave

	atw_bus_state_t state_q;
	atw_bus_state_t state_d;
	atw_aphase_t aph_q;
	atw_aphase_t aph_d;
	logic [31:0] hrdata_q;
	logic [31:0] reload_value_reg_q;
	logic [1:0] control_reg_q;
	logic write_lock_q;
	logic raw_irq_status_q;
	logic pend_reload_q;
	logic [31:0] cnt_q;
	logic en_seen_q;
	logic stopped_q;

	// Only words are served; other sizes still take the slot but act as words
	wire take_aph = hsel && htrans[ATW_HTRANS_ACTIVE_BIT] && hready;
	wire in_wr = (state_q == ATW_S_WRITE);
	wire wr_open = in_wr && !write_lock_q;
	wire hit_reload = (aph_q.addr == ATW_OFS_RELOAD);
	wire hit_control = (aph_q.addr == ATW_OFS_CONTROL);
	wire hit_clear = (aph_q.addr == ATW_OFS_IRQ_CLEAR);
	wire hit_lock = (aph_q.addr == ATW_OFS_WRITE_LOCK);
	wire reload_wr = wr_open && hit_reload;
	wire control_wr = wr_open && hit_control;
	wire clear_wr = wr_open && hit_clear;
	wire lock_wr = in_wr && hit_lock;
	wire masked_irq_status = raw_irq_status_q && control_reg_q[ATW_CTRL_IRQ_COUNT_EN];

	wire [31:0] lock_read = write_lock_q ? ATW_LOCK_READ_LOCKED : ATW_LOCK_READ_OPEN;
	wire [31:0] rd_mux =
		(aph_q.addr == ATW_OFS_RELOAD) ? reload_value_reg_q :
		(aph_q.addr == ATW_OFS_VALUE) ? cnt_q :
		(aph_q.addr == ATW_OFS_CONTROL) ? {30'h0, control_reg_q} :
		(aph_q.addr == ATW_OFS_RAW_STATUS) ? {31'h0, raw_irq_status_q} :
		(aph_q.addr == ATW_OFS_MASKED_STATUS) ? {31'h0, masked_irq_status} :
		(aph_q.addr == ATW_OFS_WRITE_LOCK) ? lock_read :
		ATW_READ_ZERO;

	// Reads take one wait state so data always comes from a flop after any prior write
	always_comb begin
		state_d = state_q;
		aph_d = aph_q;
		unique case (state_q)
			ATW_S_READ_WAIT: begin
				state_d = ATW_S_READ_DONE;
			end
			ATW_S_IDLE, ATW_S_WRITE, ATW_S_READ_DONE: begin
				if (take_aph) begin
					aph_d.addr = haddr[11:0];
					aph_d.write = hwrite;
					state_d = hwrite ? ATW_S_WRITE : ATW_S_READ_WAIT;
				end else begin
					state_d = ATW_S_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ATW_S_IDLE;
			aph_q <= '0;
			hrdata_q <= ATW_READ_ZERO;
		end else begin
			state_q <= state_d;
			aph_q <= aph_d;
			if (state_q == ATW_S_READ_WAIT) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	assign hreadyout = (state_q != ATW_S_READ_WAIT);
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reload_value_reg_q <= ATW_RELOAD_RST;
			control_reg_q <= ATW_CONTROL_RST;
			write_lock_q <= 1'b0;
		end else begin
			if (reload_wr) begin
				reload_value_reg_q <= hwdata;
			end
			if (control_wr) begin
				control_reg_q <= hwdata[1:0];
			end
			if (lock_wr) begin
				write_lock_q <= (hwdata != ATW_UNLOCK_KEY);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter and event logic

	// Counting edges share hclk edges, so bus events need only a pending flag
	wire tick = count_clock_enable;
	wire run = control_reg_q[ATW_CTRL_IRQ_COUNT_EN] && !stopped_q;
	wire reload_now = !en_seen_q || pend_reload_q;
	wire cnt_zero = (cnt_q == ATW_READ_ZERO);
	wire zero_hit = tick && run && !reload_now && cnt_zero;
	wire fire_rst = zero_hit && raw_irq_status_q && control_reg_q[ATW_CTRL_RESET_OUT_EN];
	wire [31:0] cnt_dec = cnt_q - ATW_COUNT_ONE;
	wire [31:0] cnt_d = !(tick && run) ? cnt_q :
		(reload_now || (zero_hit && !fire_rst)) ? reload_value_reg_q :
		fire_rst ? cnt_q : cnt_dec;

	// Event set wins over consumption and clear in the same cycle
	wire pend_d = reload_wr || clear_wr || (pend_reload_q && !(tick && run));
	wire raw_d = zero_hit || (raw_irq_status_q && !clear_wr);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reload_q <= 1'b0;
			raw_irq_status_q <= 1'b0;
		end else begin
			pend_reload_q <= pend_d;
			raw_irq_status_q <= raw_d;
		end
	end

	always_ff @(posedge hclk or negedge count_domain_reset_n) begin
		if (!count_domain_reset_n) begin
			cnt_q <= ATW_COUNT_RST;
			en_seen_q <= 1'b0;
			stopped_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			en_seen_q <= control_reg_q[ATW_CTRL_IRQ_COUNT_EN] && (en_seen_q || (tick && run));
			stopped_q <= stopped_q || fire_rst;
		end
	end

	assign timeout_irq = masked_irq_status;
	assign timeout_reset_out = stopped_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking atw_cb @(posedge hclk); endclocking
	default disable iff (!hresetn || !count_domain_reset_n);

	wire cnt_running = tick && run && !reload_now && !cnt_zero;

	AST_CNT_HOLD_NO_TICK: assert property (!tick |=> $stable(cnt_q))
		else $error("Counter moved without an enabled edge");

	AST_CNT_DECREMENT: assert property (cnt_running |=> cnt_q == $past(cnt_q) - 32'h0000_0001)
		else $error("Counter did not decrement by one");

	AST_ZERO_RAISES_IRQ: assert property (zero_hit && !fire_rst
		|=> raw_irq_status_q && cnt_q == $past(reload_value_reg_q))
		else $error("Zero count did not raise interrupt and reload");

	AST_RESET_ON_UNCLEARED: assert property (zero_hit && raw_irq_status_q
		&& control_reg_q[ATW_CTRL_RESET_OUT_EN] |=> timeout_reset_out)
		else $error("Reset output not asserted on uncleared timeout");

	AST_STOPPED_HOLDS: assert property (timeout_reset_out |=> $stable(cnt_q) [*3])
		else $error("Counter moved after reset output");

	AST_NO_RESET_WHEN_MASKED: assert property (!timeout_reset_out
		&& !control_reg_q[ATW_CTRL_RESET_OUT_EN] |=> !timeout_reset_out)
		else $error("Reset output rose while masked");

	AST_FREEZE_DISABLED: assert property (!control_reg_q[ATW_CTRL_IRQ_COUNT_EN] |=> $stable(cnt_q))
		else $error("Counter moved while disabled");

	AST_ENABLE_LOADS: assert property (tick && run && !en_seen_q
		|=> cnt_q == $past(reload_value_reg_q))
		else $error("Enable did not load the reload value");

	AST_LOCK_BLOCKS_WRITE: assert property (in_wr && write_lock_q && hit_reload
		|=> $stable(reload_value_reg_q))
		else $error("Locked write changed the reload register");

	AST_LOCK_READBACK: assert property (state_q == ATW_S_READ_WAIT && hit_lock
		|=> hrdata == {31'h0, $past(write_lock_q)})
		else $error("Lock read returned the wrong status");

	AST_CLEAR_DROPS_IRQ: assert property (clear_wr && !zero_hit |=> !timeout_irq)
		else $error("Interrupt not cleared at once");

	AST_READ_ONE_WAIT: assert property (take_aph && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("Read answer timing broken");

	////////////////////////////////////////////////////////////////////////////////
	// Event, lock and bus answer checks

	AST_RESET_STICKY: assert property (timeout_reset_out
		|=> timeout_reset_out)
		else $error("Reset output dropped without a counter reset");

	AST_PENDING_RELOADS: assert property (tick && run && pend_reload_q
		|=> cnt_q == $past(reload_value_reg_q))
		else $error("Pending reload not applied on the enabled edge");

	AST_CLEAR_RELOADS: assert property (clear_wr
		|=> pend_reload_q)
		else $error("Clear write did not request a reload");

	AST_RELOAD_KEEPS_IRQ: assert property (reload_wr && raw_irq_status_q
		|=> raw_irq_status_q)
		else $error("Reload write cleared a pending interrupt");

	AST_IRQ_ONLY_FROM_ZERO: assert property (!raw_irq_status_q && !zero_hit
		|=> !raw_irq_status_q)
		else $error("Interrupt raised without a zero count");

	AST_UNLOCK_KEY: assert property (lock_wr && hwdata == ATW_UNLOCK_KEY
		|=> !write_lock_q)
		else $error("Key write did not unlock");

	AST_LOCK_OTHER: assert property (lock_wr && hwdata != ATW_UNLOCK_KEY
		|=> write_lock_q)
		else $error("Non-key write did not lock");

	AST_REFUSED_CONTROL: assert property (in_wr && write_lock_q && hit_control
		|=> $stable(control_reg_q))
		else $error("Locked write changed the control register");

	AST_CTRL_WRITE_LANDS: assert property (control_wr
		|=> control_reg_q == $past(hwdata[1:0]))
		else $error("Open control write did not land");

	AST_WRITE_NO_WAIT: assert property (take_aph && hwrite
		|=> hreadyout)
		else $error("Write data phase was stretched");

	AST_READ_HOLDS_DATA: assert property (state_q != ATW_S_READ_WAIT
		|=> $stable(hrdata))
		else $error("Read data changed outside a read");

	// Zero reload is legal but fires on every enabled edge; worth seeing once
	COV_ZERO_RELOAD: cover property (zero_hit && reload_value_reg_q == ATW_READ_ZERO);
	COV_ZERO_HIT: cover property (zero_hit);
	COV_RESET_OUT: cover property ($rose(timeout_reset_out));
	COV_CLEAR_PENDING: cover property (clear_wr && raw_irq_status_q);
	COV_LOCK_THEN_UNLOCK: cover property ($fell(write_lock_q));

endmodule : atw_timeout_watchdog

// ### verif/atw_ahb_master.sv
// Bus master model: single-word AHB-Lite transfers on behalf of the processor
`timescale 1ns/1ns
module atw_ahb_master (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	logic [31:0] rd_s;
	initial begin
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
	end
	// Samples hready and hrdata at the rising edge, before that edge's updates land
	task automatic wt();
		@(posedge hclk);
		while (hready !== 1'b1) begin
			@(posedge hclk);
		end
		rd_s = hrdata;
	endtask : wt
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'b10;
		hwrite <= w;
		wt();
		// Address is unqualified now, so it must not keep its old value
		hsel <= 1'b0;
		haddr <= ~haddr;
		htrans <= 2'b00;
		hwdata <= wd;
		wt();
		hwdata <= ~wd;
		rd = rd_s;
	endtask : xfer
endmodule : atw_ahb_master

// ### verif/tb_atw_timeout_watchdog.sv
// Testbench: timeout watchdog behind a bus master model, results checked from a queue
`timescale 1ns/1ns
module tb_atw_timeout_watchdog;
	import atw_pkg::*;
	localparam logic [31:0] z0 = 32'h0000_0000;
	localparam logic [31:0] one = 32'h0000_0001;
	logic hclk, hresetn, cnt_en, cnt_rst_n, hsel, hwrite, rdy, hresp, irq, rst_out, res_stb;
	logic [31:0] haddr, hwdata, hrdata, res_dat, d, e;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] exp_q[$];
	logic [11:0] ofs[7] = '{ATW_OFS_RELOAD, ATW_OFS_VALUE, ATW_OFS_CONTROL,
		ATW_OFS_WRITE_LOCK, ATW_OFS_RAW_STATUS, ATW_OFS_MASKED_STATUS, 12'h100};
	logic [31:0] rst[7] = '{ATW_RELOAD_RST, ATW_COUNT_RST, z0, z0, z0, z0, z0};
	int mismatches, num_checks, seed, r;
	atw_timeout_watchdog dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
		.hreadyout(rdy), .hresp(hresp), .hrdata(hrdata), .count_clock_enable(cnt_en),
		.count_domain_reset_n(cnt_rst_n), .timeout_irq(irq), .timeout_reset_out(rst_out));
	atw_ahb_master mst_u (.hclk(hclk), .hready(rdy), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	////////////////////////////////////////////////////////////////
	task automatic post(input logic [31:0] act, input logic [31:0] ex);
		exp_q.push_back(ex);
		res_dat <= act;
		res_stb <= 1'b1;
		@(posedge hclk);
		res_stb <= 1'b0;
	endtask : post
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		mst_u.xfer(1'b1, a, v, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] ex);
		mst_u.xfer(1'b0, a, z0, d);
		post(d, ex);
		post({31'h0, hresp}, z0);
	endtask : rd
	// Pins are read at the falling edge so that no update of the rising edge is missed
	task automatic pin(input logic s, input logic ex);
		@(negedge hclk);
		post({31'h0, s ? rst_out : irq}, {31'h0, ex});
	endtask : pin
	// Counting is stepped by hand, one enabled edge per cycle, which fixes every count
	task automatic tick(input int n);
		cnt_en <= 1'b1;
		repeat (n) @(posedge hclk);
		cnt_en <= 1'b0;
		@(posedge hclk);
	endtask : tick
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	always @(posedge hclk) begin
		if (res_stb === 1'b1) begin
			num_checks++;
			e = exp_q.pop_front();
			if (res_dat !== e) begin
				mismatches++;
				$display("unexpected at %0t: got %h expected %h", $time, res_dat, e);
			end
		end
	end
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		repeat (3000) @(posedge hclk);
		mismatches++;
		results();
	end
	initial begin
		{hresetn, cnt_rst_n, cnt_en, res_stb, res_dat} = '0;
		seed = 68;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		cnt_rst_n <= 1'b1;
		@(posedge hclk);
		foreach (ofs[i]) rd(ofs[i], rst[i]);
		wr(ATW_OFS_WRITE_LOCK, ATW_UNLOCK_KEY ^ (one << ($unsigned($random(seed)) % 32)));
		rd(ATW_OFS_WRITE_LOCK, ATW_LOCK_READ_LOCKED);
		wr(ATW_OFS_RELOAD, 32'h0000_0005);
		rd(ATW_OFS_RELOAD, ATW_RELOAD_RST);
		wr(ATW_OFS_WRITE_LOCK, ATW_UNLOCK_KEY);
		rd(ATW_OFS_WRITE_LOCK, ATW_LOCK_READ_OPEN);
		$display("test reset and lock done");
		r = 4 + ($unsigned($random(seed)) % 8);
		wr(ATW_OFS_RELOAD, 32'(r));
		wr(ATW_OFS_CONTROL, one);
		rd(ATW_OFS_VALUE, ATW_COUNT_RST);
		tick(1);
		rd(ATW_OFS_VALUE, 32'(r));
		tick(r);
		pin(1'b0, 1'b0);
		tick(1);
		pin(1'b0, 1'b1);
		rd(ATW_OFS_VALUE, 32'(r));
		tick(2);
		wr(ATW_OFS_IRQ_CLEAR, $random(seed));
		pin(1'b0, 1'b0);
		tick(1);
		rd(ATW_OFS_VALUE, 32'(r));
		$display("test interval and clear done");
		wr(ATW_OFS_RELOAD, z0);
		tick(3);
		rd(ATW_OFS_RAW_STATUS, one);
		pin(1'b1, 1'b0);
		wr(ATW_OFS_RELOAD, 32'(r));
		tick(3);
		rd(ATW_OFS_VALUE, 32'(r - 2));
		rd(ATW_OFS_RAW_STATUS, one);
		wr(ATW_OFS_CONTROL, z0);
		tick(3);
		rd(ATW_OFS_VALUE, 32'(r - 2));
		rd(ATW_OFS_MASKED_STATUS, z0);
		wr(ATW_OFS_CONTROL, 32'h0000_0003);
		rd(ATW_OFS_MASKED_STATUS, one);
		tick(1);
		rd(ATW_OFS_VALUE, 32'(r));
		tick(r + 1);
		pin(1'b1, 1'b1);
		tick(2);
		rd(ATW_OFS_VALUE, z0);
		wr(ATW_OFS_WRITE_LOCK, z0);
		wr(ATW_OFS_CONTROL, z0);
		rd(ATW_OFS_CONTROL, 32'h0000_0003);
		cnt_rst_n <= 1'b0;
		@(posedge hclk);
		cnt_rst_n <= 1'b1;
		@(posedge hclk);
		pin(1'b1, 1'b0);
		$display("test reset output done");
		results();
	end
endmodule : tb_atw_timeout_watchdog
